// >>> vptc_pkg.sv
// Constants, register map and helpers for the valve position teach controller
//
// Overview of operation
// - Three-solenoid profile: input 0 drives main, 1 upper lift, 2 lower lift only.
// - Three-solenoid profile: closed for pattern 1,0,1,0; open for pattern 0,0,0,1.
// - Single-solenoid profile: only closed and open; signal c unused; input 0 drives main.
// - Feedback only while position lies within plus or minus 1 mm of taught position.
// - Measurement covers 0 to 72 mm; all taught positions lie inside that span.
// - Teach-in starts only after the key is held continuously for 3 seconds.
// - During teach-in light indicator, drive valve through each position, capture each.
// - Captured positions are written to nonvolatile storage to survive power loss.
// - Untaught state blinks indicators 3 to 6 and 9.
// - Teach-in blinks power/diagnosis pair; controller must not command the valve then.
// - Successful teach-in turns indicator off and accepts controller commands again.
// - Failed teach-in blinks teach indicator; retry needs a fresh 3-second press.
// - Pulsation enabled and seat lift commanded: that solenoid toggles on and off.
// - Pulsation on-time and off-time are separately configurable.
// - While pulsing, that seat lift feedback stays asserted regardless of position.
// - Overload on sensor or output current path sets the service request.
package vptc_pkg;
  // Position LSB is 0.01 mm
  localparam int POS_W = 16;
  localparam logic [15:0] SPAN_MAX_POS = 16'h1C20;
  localparam logic [15:0] TOL_POS = 16'h0064;
  localparam logic [15:0] MIN_STROKE_POS = 16'h01F4;
  localparam logic [15:0] MIN_LIFT_POS = 16'h0032;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_CYC = CLK_HZ / 1000;
  localparam int TEACH_HOLD_S = 3;
  localparam int TEACH_HOLD_MS = TEACH_HOLD_S * 1000;
  localparam int SETTLE_MS = 2000;
  localparam int BLINK_MS = 500;
  localparam int PULSE_MIN_S = 30;
  localparam logic [15:0] PULSE_RST = 16'(PULSE_MIN_S * 1000);
  // Register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_IRQ_ST = 6'h08;
  localparam logic [5:0] REG_IRQ_MASK = 6'h0C;
  localparam logic [5:0] REG_PULSE_ON = 6'h10;
  localparam logic [5:0] REG_PULSE_OFF = 6'h14;
  localparam logic [5:0] REG_POSITION = 6'h18;
  localparam logic [5:0] REG_REF0 = 6'h1C;
  // Control bits
  localparam int CTRL_THREE = 0;
  localparam int CTRL_PULSE = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_OVL = 2;
  localparam int IRQ_START = 3;
  localparam int IRQ_N = 4;
  // Nonvolatile words: four positions then a marker
  localparam logic [2:0] NV_LAST = 3'h4;
  localparam logic [15:0] NV_MARK = 16'hA5C3;
  typedef enum logic [3:0] {
    ST_LOAD = 4'h0,
    ST_RUN = 4'h1,
    ST_T_CLOSE = 4'h2,
    ST_T_OPEN = 4'h3,
    ST_T_UPPER = 4'h4,
    ST_T_LOWER = 4'h5,
    ST_T_BASE = 4'h6,
    ST_STORE = 4'h7,
    ST_FAIL = 4'h8
  } vptc_state_t;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    be_merge = r;
  endfunction
endpackage

// >>> vptc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module vptc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // vptc_sync
`default_nettype wire

// >>> vptc_window.sv
// Tolerance window compare of a measured position against a taught position
`timescale 1ns/1ps
`default_nettype none
module vptc_window (
  // Positions
  input wire logic [15:0] pos_i,
  input wire logic [15:0] ref_i,
  // Result
  output logic in_o
);
  assign in_o = vptc_pkg::absdiff(pos_i, ref_i) <= vptc_pkg::TOL_POS;
endmodule // vptc_window
`default_nettype wire

// >>> vptc_top.sv
// Valve position teach controller: solenoids, feedback, teach-in, pulsation, registers
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vptc_top #(
  parameter int TICK_CYC = vptc_pkg::TICK_CYC,
  parameter int SETTLE_MS = vptc_pkg::SETTLE_MS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // Plant controller pins
  input wire logic [2:0] cmd_i,
  output logic [2:0] solenoid_o,
  output logic fb_closed_o,
  output logic fb_open_o,
  output logic fb_upper_o,
  output logic fb_lower_o,
  // Sensor, key, overload, indicators
  input wire logic [15:0] position_i,
  input wire logic position_valid_i,
  input wire logic teach_key_i,
  input wire logic [1:0] overload_i,
  output logic service_request_o,
  output logic [8:0] led_o,
  // Nonvolatile store
  output logic nvm_req_o,
  output logic nvm_we_o,
  output logic [2:0] nvm_addr_o,
  output logic [15:0] nvm_wdata_o,
  input wire logic [15:0] nvm_rdata_i,
  input wire logic nvm_ack_i
);
  vptc_pkg::vptc_state_t state_q;
  vptc_pkg::vptc_state_t state_d;
  logic [5:0] pins_s;
  logic [2:0] cmd_s;
  logic key_s;
  logic [1:0] ovl_s;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [15:0] key_cnt_q;
  logic key_start;
  logic [15:0] st_cnt_q;
  logic settled;
  logic [2:0] nv_idx_q;
  logic [15:0] pos_q;
  logic [15:0] cap_q [4];
  logic [15:0] ref_q [4];
  logic taught_q;
  logic [3:0] win;
  logic sig_a;
  logic sig_b;
  logic sig_c;
  logic sig_d;
  logic three;
  logic running;
  logic teach_ok;
  logic teaching;
  logic [1:0] ctrl_q;
  logic [15:0] pulse_on_q;
  logic [15:0] pulse_off_q;
  logic pulsing;
  logic phase_q;
  logic [15:0] pcnt_q;
  logic [2:0] sol_d;
  logic [15:0] blink_cnt_q;
  logic blink_q;
  logic ack_q;
  logic bus_req;
  logic [31:0] rd_mux;
  logic [vptc_pkg::IRQ_N-1:0] irq_st_q;
  logic [vptc_pkg::IRQ_N-1:0] irq_mask_q;
  logic [vptc_pkg::IRQ_N-1:0] irq_set;
  logic wr_now;

  vptc_sync #(.W(6)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .d_i({overload_i, teach_key_i, cmd_i}),
    .q_o(pins_s)
  );
  assign cmd_s = pins_s[2:0];
  assign key_s = pins_s[3];
  assign ovl_s = pins_s[5:4];

  // Millisecond tick
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // key hold timer; restarts on release
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      key_cnt_q <= 16'h0;
    else if (!key_s)
      key_cnt_q <= 16'h0;
    else if (tick_q && key_cnt_q != 16'(vptc_pkg::TEACH_HOLD_MS))
      key_cnt_q <= key_cnt_q + 16'h1;
  end
  // one start per press, fresh press needed to retry
  assign key_start = tick_q && key_s && (key_cnt_q == 16'(vptc_pkg::TEACH_HOLD_MS - 1));

  // Measured position
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      pos_q <= 16'h0;
    else if (position_valid_i)
      pos_q <= position_i;
  end

  assign three = ctrl_q[vptc_pkg::CTRL_THREE];
  assign running = (state_q == vptc_pkg::ST_RUN) && taught_q;
  assign teaching = (state_q >= vptc_pkg::ST_T_CLOSE) && (state_q <= vptc_pkg::ST_STORE);
  assign settled = tick_q && (st_cnt_q == 16'(SETTLE_MS - 1));

  // span check; missing air shows as no stroke
  always_comb
  begin
    teach_ok = (vptc_pkg::absdiff(cap_q[1], cap_q[0]) >= vptc_pkg::MIN_STROKE_POS)
      && (vptc_pkg::absdiff(pos_q, cap_q[0]) <= vptc_pkg::TOL_POS);
    for (int i = 0; i < 4; i++)
      if ((i < 2 || three) && cap_q[i] > vptc_pkg::SPAN_MAX_POS)
        teach_ok = 1'b0;
    if (three && (vptc_pkg::absdiff(cap_q[2], cap_q[0]) < vptc_pkg::MIN_LIFT_POS
        || vptc_pkg::absdiff(cap_q[3], cap_q[0]) < vptc_pkg::MIN_LIFT_POS))
      teach_ok = 1'b0;
  end

  // Sequence control
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      vptc_pkg::ST_LOAD:
        if (nvm_ack_i && nv_idx_q == vptc_pkg::NV_LAST)
          state_d = vptc_pkg::ST_RUN;
      vptc_pkg::ST_RUN, vptc_pkg::ST_FAIL:
        if (key_start)
          state_d = vptc_pkg::ST_T_CLOSE;
      // walk closed, open, lifts (three-solenoid only), back to basic
      vptc_pkg::ST_T_CLOSE:
        if (settled)
          state_d = vptc_pkg::ST_T_OPEN;
      vptc_pkg::ST_T_OPEN:
        if (settled)
          state_d = three ? vptc_pkg::ST_T_UPPER : vptc_pkg::ST_T_BASE;
      vptc_pkg::ST_T_UPPER:
        if (settled)
          state_d = vptc_pkg::ST_T_LOWER;
      vptc_pkg::ST_T_LOWER:
        if (settled)
          state_d = vptc_pkg::ST_T_BASE;
      vptc_pkg::ST_T_BASE:
        if (settled)
          state_d = teach_ok ? vptc_pkg::ST_STORE : vptc_pkg::ST_FAIL;
      vptc_pkg::ST_STORE:
        if (nvm_ack_i && nv_idx_q == vptc_pkg::NV_LAST)
          state_d = vptc_pkg::ST_RUN;
      default:
        state_d = vptc_pkg::ST_FAIL;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= vptc_pkg::ST_LOAD;
      st_cnt_q <= 16'h0;
      nv_idx_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
        st_cnt_q <= 16'h0;
      else if (tick_q)
        st_cnt_q <= st_cnt_q + 16'h1;
      if (state_d != state_q)
        nv_idx_q <= 3'h0;
      else if (nvm_ack_i)
        nv_idx_q <= nv_idx_q + 3'h1;
    end
  end

  // Captures during teach-in
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      for (int i = 0; i < 4; i++)
        cap_q[i] <= 16'h0;
    else if (settled)
      unique case (state_q)
        vptc_pkg::ST_T_CLOSE: cap_q[0] <= pos_q;
        vptc_pkg::ST_T_OPEN: cap_q[1] <= pos_q;
        vptc_pkg::ST_T_UPPER: cap_q[2] <= pos_q;
        vptc_pkg::ST_T_LOWER: cap_q[3] <= pos_q;
        default: ;
      endcase
  end

  // Taught references: restored at power-up, replaced after a good store
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      taught_q <= 1'b0;
      for (int i = 0; i < 4; i++)
        ref_q[i] <= 16'h0;
    end
    else if (state_q == vptc_pkg::ST_LOAD && nvm_ack_i)
    begin
      if (nv_idx_q == vptc_pkg::NV_LAST)
        taught_q <= (nvm_rdata_i == vptc_pkg::NV_MARK);
      else
        ref_q[nv_idx_q[1:0]] <= nvm_rdata_i;
    end
    else if (state_q == vptc_pkg::ST_STORE && nvm_ack_i && nv_idx_q == vptc_pkg::NV_LAST)
    begin
      taught_q <= 1'b1;
      for (int i = 0; i < 4; i++)
        ref_q[i] <= cap_q[i];
    end
    else if (state_d == vptc_pkg::ST_FAIL)
      taught_q <= 1'b0;
  end

  // nonvolatile read at power-up, write after teach
  assign nvm_req_o = (state_q == vptc_pkg::ST_LOAD) || (state_q == vptc_pkg::ST_STORE);
  assign nvm_we_o = (state_q == vptc_pkg::ST_STORE);
  assign nvm_addr_o = nv_idx_q;
  assign nvm_wdata_o = (nv_idx_q == vptc_pkg::NV_LAST) ? vptc_pkg::NV_MARK : cap_q[nv_idx_q[1:0]];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_win
      vptc_window u_win (
        .pos_i(pos_q),
        .ref_i(ref_q[g]),
        .in_o(win[g])
      );
    end
  endgenerate

  // Position signals a..d from taught windows
  assign sig_a = win[0] || (three && win[3]);
  assign sig_b = three && win[2];
  assign sig_c = three && (win[0] || win[2]);
  assign sig_d = win[1];

  // pulsation phase; separate on and off times
  assign pulsing = running && three && ctrl_q[vptc_pkg::CTRL_PULSE] && (cmd_s[1] || cmd_s[2]);
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || !pulsing)
    begin
      phase_q <= 1'b1;
      pcnt_q <= 16'h0;
    end
    else if (tick_q)
    begin
      if ({1'b0, pcnt_q} + 17'h1 >= {1'b0, phase_q ? pulse_on_q : pulse_off_q})
      begin
        phase_q <= !phase_q;
        pcnt_q <= 16'h0;
      end
      else
        pcnt_q <= pcnt_q + 16'h1;
    end
  end

  // Solenoid drive per state
  always_comb
  begin
    sol_d = 3'h0;
    unique case (state_q)
      vptc_pkg::ST_T_OPEN: sol_d = 3'h1;
      vptc_pkg::ST_T_UPPER: sol_d = 3'h2;
      vptc_pkg::ST_T_LOWER: sol_d = 3'h4;
      vptc_pkg::ST_RUN:
        if (taught_q)
        begin
          // one input, one solenoid; single profile main only
          sol_d[0] = cmd_s[0];
          sol_d[1] = three && cmd_s[1] && (phase_q || !pulsing);
          sol_d[2] = three && cmd_s[2] && (phase_q || !pulsing);
        end
      default: sol_d = 3'h0;
    endcase
  end

  // Solenoids and feedback outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      solenoid_o <= 3'h0;
      fb_closed_o <= 1'b0;
      fb_open_o <= 1'b0;
      fb_upper_o <= 1'b0;
      fb_lower_o <= 1'b0;
    end
    else
    begin
      solenoid_o <= sol_d;
      // closed 1,0,1,0 and open 0,0,0,1; signal c ignored in single profile
      fb_closed_o <= running && sig_a && !sig_b && (sig_c || !three) && !sig_d;
      fb_open_o <= running && !sig_a && !sig_b && !sig_c && sig_d;
      // lifts 0,1,1,0 and 1,0,0,0; forced while pulsing
      fb_upper_o <= running && three && ((!sig_a && sig_b && sig_c && !sig_d) || (pulsing && cmd_s[1]));
      fb_lower_o <= running && three && ((sig_a && !sig_b && !sig_c && !sig_d) || (pulsing && cmd_s[2]));
    end
  end

  // Blink timebase
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      blink_cnt_q <= 16'h0;
      blink_q <= 1'b0;
    end
    else if (tick_q)
    begin
      if (blink_cnt_q == 16'(vptc_pkg::BLINK_MS - 1))
      begin
        blink_cnt_q <= 16'h0;
        blink_q <= !blink_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 16'h1;
    end
  end

  // Indicators, bit n is indicator n+1
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      led_o <= 9'h0;
    else
    begin
      led_o <= 9'h0;
      led_o[0] <= solenoid_o[1] || solenoid_o[2];
      led_o[1] <= solenoid_o[0];
      led_o[7] <= service_request_o;
      if (teaching)
      begin
        // teach indicator lit; power/diagnosis pair alternates
        led_o[8] <= 1'b1;
        led_o[2] <= blink_q;
        led_o[3] <= !blink_q;
      end
      else if (state_q == vptc_pkg::ST_FAIL)
      begin
        led_o[8] <= blink_q;
        led_o[2] <= 1'b1;
      end
      else if (state_q == vptc_pkg::ST_RUN && !taught_q)
      begin
        led_o[5:2] <= {4{blink_q}};
        led_o[8] <= blink_q;
      end
      else if (running)
      begin
        led_o[2] <= !service_request_o || blink_q;
        led_o[3] <= service_request_o && !blink_q;
        led_o[4] <= fb_closed_o;
        led_o[5] <= fb_open_o;
      end
    end
  end

  // Avalon-MM: one wait cycle per access
  assign bus_req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !ack_q;
  assign wr_now = avs_write_i && ack_q;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (avs_address_i)
      vptc_pkg::REG_CTRL: rd_mux = {30'h0, ctrl_q};
      vptc_pkg::REG_STATUS:
        rd_mux = {16'h0, solenoid_o, fb_lower_o, fb_upper_o, fb_open_o, fb_closed_o,
                  sig_d, sig_c, sig_b, sig_a, taught_q, state_q};
      vptc_pkg::REG_IRQ_ST: rd_mux = {28'h0, irq_st_q};
      vptc_pkg::REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
      vptc_pkg::REG_PULSE_ON: rd_mux = {16'h0, pulse_on_q};
      vptc_pkg::REG_PULSE_OFF: rd_mux = {16'h0, pulse_off_q};
      vptc_pkg::REG_POSITION: rd_mux = {16'h0, pos_q};
      6'h1C, 6'h20, 6'h24, 6'h28: rd_mux = {16'h0, ref_q[2'(avs_address_i[5:2] - 4'h7)]};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0;
    end
    else
    begin
      ack_q <= bus_req && !ack_q;
      if (avs_read_i && !ack_q)
        avs_readdata_o <= rd_mux;
    end
  end

  // Writable registers
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= vptc_pkg::CTRL_RST;
      irq_mask_q <= '0;
      pulse_on_q <= vptc_pkg::PULSE_RST;
      pulse_off_q <= vptc_pkg::PULSE_RST;
    end
    else if (wr_now)
    begin
      unique case (avs_address_i)
        vptc_pkg::REG_CTRL:
          ctrl_q <= 2'(vptc_pkg::be_merge({30'h0, ctrl_q}, avs_writedata_i, avs_byteenable_i));
        vptc_pkg::REG_IRQ_MASK:
          irq_mask_q <= 4'(vptc_pkg::be_merge({28'h0, irq_mask_q}, avs_writedata_i, avs_byteenable_i));
        vptc_pkg::REG_PULSE_ON:
          pulse_on_q <= 16'(vptc_pkg::be_merge({16'h0, pulse_on_q}, avs_writedata_i, avs_byteenable_i));
        vptc_pkg::REG_PULSE_OFF:
          pulse_off_q <= 16'(vptc_pkg::be_merge({16'h0, pulse_off_q}, avs_writedata_i, avs_byteenable_i));
        default: ;
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  always_comb
  begin
    irq_set = '0;
    irq_set[vptc_pkg::IRQ_DONE] = state_q == vptc_pkg::ST_STORE && state_d == vptc_pkg::ST_RUN;
    irq_set[vptc_pkg::IRQ_FAIL] = state_q != vptc_pkg::ST_FAIL && state_d == vptc_pkg::ST_FAIL;
    irq_set[vptc_pkg::IRQ_OVL] = |ovl_s;
    irq_set[vptc_pkg::IRQ_START] = key_start && !teaching && state_q != vptc_pkg::ST_LOAD;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      irq_st_q <= '0;
    else if (wr_now && avs_address_i == vptc_pkg::REG_IRQ_ST && avs_byteenable_i[0])
      irq_st_q <= (irq_st_q & ~avs_writedata_i[vptc_pkg::IRQ_N-1:0]) | irq_set;
    else
      irq_st_q <= irq_st_q | irq_set;
  end

  assign irq_o = |(irq_st_q & irq_mask_q);
  assign service_request_o = irq_st_q[vptc_pkg::IRQ_OVL];
endmodule // vptc_top
`default_nettype wire

// >>> vptc_monitor.sv
// Port assertions for the valve position teach controller
`timescale 1ns/1ps
`default_nettype none
module vptc_monitor (
  // Clock, reset, bus
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // Plant and indicators
  input wire logic [2:0] cmd_i,
  input wire logic [2:0] solenoid_o,
  input wire logic fb_closed_o,
  input wire logic fb_open_o,
  input wire logic fb_lower_o,
  input wire logic [1:0] overload_i,
  input wire logic service_request_o,
  input wire logic [8:0] led_o,
  // Nonvolatile store
  input wire logic nvm_req_o,
  input wire logic nvm_we_o,
  input wire logic [2:0] nvm_addr_o,
  input wire logic [15:0] nvm_wdata_o,
  input wire logic nvm_ack_i
);
  logic teach;
  // Teaching shows as lit teach lamp with the pair alternating
  assign teach = led_o[8] && (led_o[2] != led_o[3]);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_main;
    solenoid_o[0] && !teach |-> $past(cmd_i[0], 3) || $past(cmd_i[0], 4) || $past(teach);
  endproperty
  a_main: assert property (p_main) else $error("main solenoid without command");
  property p_lift;
    (solenoid_o[1] && !teach) |-> $past(cmd_i[1], 3) || $past(cmd_i[1], 4) || $past(teach);
  endproperty
  a_lift: assert property (p_lift) else $error("upper lift without command");
  property p_fb_excl;
    !(fb_closed_o && fb_open_o) && !(fb_open_o && fb_lower_o && !$past(cmd_i[2], 3));
  endproperty
  a_fb_excl: assert property (p_fb_excl) else $error("conflicting feedback");
  property p_svc_set;
    (overload_i != 2'h0) [*6] |-> service_request_o;
  endproperty
  a_svc_set: assert property (p_svc_set) else $error("overload not reported");
  property p_svc_hold;
    service_request_o && !(avs_write_i && avs_address_i == 6'h08) |=> service_request_o;
  endproperty
  a_svc_hold: assert property (p_svc_hold) else $error("service request dropped");
  property p_nvm_hold;
    nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_addr_o) && $stable(nvm_we_o);
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("store request not held");
  property p_nvm_mark;
    nvm_req_o && nvm_we_o && nvm_addr_o == 3'h4 |-> nvm_wdata_o == 16'hA5C3;
  endproperty
  a_nvm_mark: assert property (p_nvm_mark) else $error("bad taught marker");
  property p_teach_one;
    teach |-> $countones(solenoid_o) <= 1;
  endproperty
  a_teach_one: assert property (p_teach_one) else $error("teach drives two solenoids");
endmodule // vptc_monitor
bind vptc_top vptc_monitor mon (.sys_clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .cmd_i, .solenoid_o, .fb_closed_o, .fb_open_o, .fb_lower_o, .overload_i,
  .service_request_o, .led_o, .nvm_req_o, .nvm_we_o, .nvm_addr_o, .nvm_wdata_o, .nvm_ack_i);
`default_nettype wire

// >>> vptc_plant_model.sv
// Valve, rod sensor and nonvolatile store seen by the controller
`timescale 1ns/1ps
`default_nettype none
module vptc_plant_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Valve
  input wire logic [2:0] solenoid_i,
  input wire logic [15:0] shift_i,
  output logic [15:0] position_o,
  output logic position_valid_o,
  // Store
  input wire logic nvm_req_i,
  input wire logic nvm_we_i,
  input wire logic [2:0] nvm_addr_i,
  input wire logic [15:0] nvm_wdata_i,
  output logic [15:0] nvm_rdata_o,
  output logic nvm_ack_o
);
  logic [15:0] mem [0:4];
  logic [1:0] wait_q;
  logic [15:0] base;
  initial
  begin
    for (int i = 0; i < 5; i++)
      mem[i] = 16'h0000;
  end
  assign base = solenoid_i[0] ? 16'h1388 : solenoid_i[1] ? 16'h05DC : solenoid_i[2] ? 16'h0320 : 16'h03E8;
  always @(posedge sys_clk_i)
  begin
    position_valid_o <= !reset_i && !position_valid_o;
    position_o <= base + shift_i;
    if (reset_i)
    begin
      nvm_ack_o <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (nvm_req_i && !nvm_ack_o && wait_q == 2'h0)
    begin
      nvm_ack_o <= 1'b1;
      nvm_rdata_o <= mem[nvm_addr_i];
      if (nvm_we_i)
        mem[nvm_addr_i] <= nvm_wdata_i;
      wait_q <= {1'b0, nvm_addr_i[0]} + 2'h1;
    end
    else
    begin
      nvm_ack_o <= 1'b0;
      nvm_rdata_o <= ~nvm_rdata_o;
      if (wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule // vptc_plant_model
`default_nettype wire

// >>> valve_position_teach_control_tb.sv
// Self-checking bench for the valve position teach controller
`timescale 1ns/1ps
`default_nettype none
module valve_position_teach_control_tb;
  localparam int TK = 4;
  logic sys_clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o, teach_key_i;
  logic fb_closed_o, fb_open_o, fb_upper_o, fb_lower_o, service_request_o;
  logic position_valid_i, nvm_req_o, nvm_we_o, nvm_ack_i;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [2:0] cmd_i, solenoid_o, nvm_addr_o;
  logic [15:0] position_i, nvm_wdata_o, nvm_rdata_i, shift;
  logic [1:0] overload_i;
  logic [8:0] led_o;
  logic [2:0] cv [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  int fails = 0, total_checks = 0, seed = 4, n, hi, bad;
  vptc_top #(.TICK_CYC(TK), .SETTLE_MS(4)) dut (.*, .avs_byteenable_i(4'hF));
  vptc_plant_model plant (.sys_clk_i, .reset_i, .solenoid_i(solenoid_o), .shift_i(shift),
    .position_o(position_i), .position_valid_o(position_valid_i), .nvm_req_i(nvm_req_o),
    .nvm_we_i(nvm_we_o), .nvm_addr_i(nvm_addr_o), .nvm_wdata_i(nvm_wdata_o),
    .nvm_rdata_o(nvm_rdata_i), .nvm_ack_o(nvm_ack_i));
  initial
  begin
    sys_clk_i = 0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask
  function automatic logic [3:0] exp_fb(input logic [2:0] c);
    exp_fb = c[0] ? 4'h2 : c[1] ? 4'h4 : c[2] ? 4'h8 : 4'h1;
  endfunction
  task tmo(input int lim);
    if (n >= lim)
    begin
      chk("wait bound", 1, 0);
      end_of_test();
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    tmo(20);
    @(posedge sys_clk_i);
  endtask
  initial
  begin
    {reset_i, avs_read_i, avs_write_i, teach_key_i} = 4'h8;
    {avs_address_i, avs_writedata_i, cmd_i, overload_i, shift} = '0;
    cyc(12);
    reset_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (nvm_req_o !== 1'b0 && n < 200);
    tmo(200);
    bus(0, 6'h00, 0);
    chk("ctrl", 32'h1, q);
    bus(0, 6'h10, 0);
    chk("pulse on", 32'h7530, q);
    bus(1, 6'h3C, 32'hFFFFFFFF);
    bus(0, 6'h3C, 0);
    chk("unmapped", 32'h0, q);
    repeat (20)
    begin
      cmd_i <= 3'($random(seed));
      cyc(3);
      chk("untaught sol", 3'h0, solenoid_o);
    end
    cmd_i <= 3'h0;
    teach_key_i <= 1'b1;
    cyc(2900 * TK);
    teach_key_i <= 1'b0;
    cyc(10 * TK);
    bus(0, 6'h08, 0);
    chk("partial press", 32'h0, q);
    teach_key_i <= 1'b1;
    n = 0;
    while (!(led_o[8] && led_o[2] !== led_o[3]) && n < 14000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("hold time", 1, n >= 2999 * TK && n <= 3004 * TK);
    teach_key_i <= 1'b0;
    n = 0;
    while (led_o[8] !== 1'b0 && n < 3000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    tmo(3000);
    cyc(100);
    bus(0, 6'h08, 0);
    chk("teach irq", 32'h9, q);
    chk("marker", 16'hA5C3, plant.mem[4]);
    chk("closed ref", 16'h03E8, plant.mem[0]);
    chk("irq masked", 0, irq_o);
    bus(1, 6'h0C, 32'h9);
    chk("irq on", 1, irq_o);
    bus(1, 6'h08, 32'h9);
    chk("irq clear", 0, irq_o);
    for (int i = 0; i < 4; i++)
    begin
      // Stay off 900, where closed and lower windows meet
      shift <= 16'($random(seed) % 100);
      cmd_i <= cv[i];
      cyc(20);
      chk("solenoids", cv[i], solenoid_o);
      chk("feedback", exp_fb(cv[i]), {fb_lower_o, fb_upper_o, fb_open_o, fb_closed_o});
    end
    cmd_i <= 3'h0;
    shift <= 16'h0064;
    cyc(20);
    chk("edge in", 1, fb_closed_o);
    shift <= 16'h0065;
    cyc(20);
    chk("edge out", 0, fb_closed_o);
    shift <= 16'h0;
    bus(1, 6'h00, 32'h0);
    cmd_i <= 3'h6;
    cyc(20);
    chk("single lifts", 3'h0, solenoid_o);
    chk("single closed", 1, fb_closed_o);
    cmd_i <= 3'h1;
    cyc(20);
    chk("single open", 2'h3, {solenoid_o[0], fb_open_o});
    // short times: model seats settle within one tick
    bus(1, 6'h10, 32'h2);
    bus(1, 6'h14, 32'h3);
    bus(1, 6'h00, 32'h3);
    cmd_i <= 3'h2;
    cyc(30);
    hi = 0;
    bad = 0;
    repeat (200)
    begin
      @(posedge sys_clk_i);
      hi += solenoid_o[1];
      bad += !fb_upper_o;
    end
    chk("pulse duty", 1, hi >= 72 && hi <= 88);
    chk("pulse feedback", 0, bad);
    cmd_i <= 3'h0;
    overload_i <= 2'h2;
    cyc(10);
    chk("overload", 1, service_request_o);
    overload_i <= 2'h0;
    cyc(5);
    chk("sticky", 1, service_request_o);
    bus(1, 6'h08, 32'h4);
    cyc(2);
    chk("cleared", 0, service_request_o);
    end_of_test();
  end
endmodule // valve_position_teach_control_tb
`default_nettype wire
